/* File: logic/asm_pkg.sv */
// Package: register map, field layout and carrier types of the monitor
package asm_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ASM_STATUS_IDX = 'h1f;
   localparam int ASM_CTRL_IDX = 'h20;
   localparam logic [7:0] ASM_STATUS_ADDR = 8'(ASM_STATUS_IDX * 4);
   localparam logic [7:0] ASM_CTRL_ADDR = 8'(ASM_CTRL_IDX * 4);

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int ASM_STATUS_LSB = 4;
   localparam int ASM_FLAG_LSB = 0;
   localparam int ASM_COND_W = 4;
   localparam int ASM_CTRL_W = 5;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [4:0] ASM_CTRL_RST = 5'h1f;
   localparam logic [3:0] ASM_STATUS_RST = 4'h0;
   localparam logic [3:0] ASM_FLAG_RST = 4'h0;

   // ----------------------------------------------------------------
   // Bus answers
   // ----------------------------------------------------------------
   localparam logic [1:0] ASM_RESP_OKAY = 2'h0;
   localparam logic [1:0] ASM_RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   // Bit order matches status bits 7..4 and flag bits 3..0
   typedef struct packed {
      logic short_dom2;
      logic short_dom1;
      logic lowvolt_dom2;
      logic lowvolt_dom1;
   } asm_cond_s;

   typedef struct packed {
      logic dom2_supply_on;
      logic dom1_supply_on;
      logic dom2_regulator_enable;
      logic dom1_regulator_enable;
      logic full_performance_mode;
   } asm_ctrl_s;

endpackage : asm_pkg

/* File: logic/asm_sync.sv */
// Two-stage synchroniser for the analog comparator levels
module asm_sync
   import asm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire asm_pkg::asm_cond_s async_in,
   output asm_pkg::asm_cond_s sync_out
);
   asm_cond_s meta_ff;
   asm_cond_s sync_ff;

   // ----------------------------------------------------------------
   // Stages
   // ----------------------------------------------------------------
   // First stage is read only by the second stage
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= ASM_STATUS_RST;
         sync_ff <= ASM_STATUS_RST;
      end else if (clk_en) begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule : asm_sync

/* File: logic/asm_flag_bank.sv */
// Sticky write-one-to-clear flag bank
module asm_flag_bank
   import asm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [3:0] set,
   input wire logic [3:0] clr,
   output logic [3:0] flag_ff
);

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < ASM_COND_W; i++) begin : g_flag
         // Set beats a clear in the same cycle so no event is lost
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               flag_ff[i] <= ASM_FLAG_RST[i];
            end else if (clk_en) begin
               if (set[i]) begin
                  flag_ff[i] <= 1'b1;
               end else if (clr[i]) begin
                  flag_ff[i] <= 1'b0;
               end
            end
         end

         chk_flag_set_wins: assert property (
            @(posedge ref_clk) disable iff (!rst_n)
            clk_en && set[i] |=> flag_ff[i])
            else $error("flag not set by its condition");

         chk_flag_sticky: assert property (
            @(posedge ref_clk) disable iff (!rst_n)
            flag_ff[i] && !clr[i] |=> flag_ff[i])
            else $error("flag dropped without a clear");

         chk_flag_clear: assert property (
            @(posedge ref_clk) disable iff (!rst_n)
            clk_en && clr[i] && !set[i] |=> !flag_ff[i])
            else $error("flag write of one did not clear it");
      end
   endgenerate

endmodule : asm_flag_bank

/* File: logic/asm_status_top.sv */
// Top: supply monitor status register with an AXI4-Lite slave
//
// Summary of operation
// - Monitors are live only in full performance mode with their regulator (bits 7, 6) or supply (bits 5, 4) enabled.
// - Bit 7: dom2 regulator on, full mode, dom2 above analog reference.
// - Bit 6: dom1 regulator on, full mode, dom1 above analog reference.
// - Bit 5: dom2 supply on, below monitor threshold, full mode.
// - Bit 4: dom1 supply on, below monitor threshold, full mode.
// - Flag bits are writable anytime; status bits ignore writes.
// - Status register sits at index 0x1f and is readable anytime.
// - Reset clears all status and flag bits; with the control reset value every bit then follows the analog level.
module asm_status_top
   import asm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire asm_pkg::asm_cond_s analog_cmp,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import asm_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic rst_meta_ff;
   logic rst_n_ff;
   asm_cond_s cond_sync;
   asm_cond_s status_ff;
   asm_cond_s nxt_status;
   asm_ctrl_s ctrl_ff;
   logic [3:0] flag_ff;
   logic [3:0] flag_clr;
   logic awready_ff;
   logic wready_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic aw_held_ff;
   logic w_held_ff;
   logic [7:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic arready_ff;
   logic rvalid_ff;
   logic [1:0] rresp_ff;
   logic [31:0] rdata_ff;
   logic aw_take;
   logic w_take;
   logic ar_take;
   logic do_write;
   logic wr_status;
   logic wr_ctrl;
   logic [31:0] nxt_rdata;
   logic [1:0] nxt_rresp;

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   // Release runs even with clk_en low so reset never stalls
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end

   // ----------------------------------------------------------------
   // Comparator inputs
   // ----------------------------------------------------------------
   asm_sync u_sync (
      .ref_clk (ref_clk),
      .rst_n (rst_n_ff),
      .clk_en (clk_en),
      .async_in (analog_cmp),
      .sync_out (cond_sync)
   );

   // ----------------------------------------------------------------
   // Status evaluation
   // ----------------------------------------------------------------
   // Every bit is gated by full performance mode and its enable
   always_comb begin
      nxt_status.short_dom2 = ctrl_ff.dom2_regulator_enable
         & ctrl_ff.full_performance_mode & cond_sync.short_dom2;
      nxt_status.short_dom1 = ctrl_ff.dom1_regulator_enable
         & ctrl_ff.full_performance_mode & cond_sync.short_dom1;
      nxt_status.lowvolt_dom2 = ctrl_ff.dom2_supply_on
         & ctrl_ff.full_performance_mode & cond_sync.lowvolt_dom2;
      nxt_status.lowvolt_dom1 = ctrl_ff.dom1_supply_on
         & ctrl_ff.full_performance_mode & cond_sync.lowvolt_dom1;
   end

   // Status is not writable from the bus at all
   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         status_ff <= ASM_STATUS_RST;
      end else if (clk_en) begin
         status_ff <= nxt_status;
      end
   end

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   // Each flag whose status bit is high rises a few cycles after
   // release, so their settled value follows the analog level
   assign flag_clr = wr_status ? wdata_ff[3:0] : 4'h0;

   asm_flag_bank u_flags (
      .ref_clk (ref_clk),
      .rst_n (rst_n_ff),
      .clk_en (clk_en),
      .set (status_ff),
      .clr (flag_clr),
      .flag_ff (flag_ff)
   );

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         ctrl_ff <= ASM_CTRL_RST;
      end else if (clk_en && wr_ctrl) begin
         ctrl_ff <= wdata_ff[ASM_CTRL_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Write channels
   // ----------------------------------------------------------------
   assign aw_take = s_axi_awvalid & awready_ff;
   assign w_take = s_axi_wvalid & wready_ff;
   assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
   assign wr_status = do_write & wstrb_ff[0]
      & (awaddr_ff[7:2] == ASM_STATUS_ADDR[7:2]);
   assign wr_ctrl = do_write & wstrb_ff[0]
      & (awaddr_ff[7:2] == ASM_CTRL_ADDR[7:2]);

   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         awready_ff <= 1'b1;
         aw_held_ff <= 1'b0;
         awaddr_ff <= 8'h00;
      end else if (clk_en) begin
         if (aw_take) begin
            awready_ff <= 1'b0;
            aw_held_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held_ff <= 1'b0;
         end else if (bvalid_ff && s_axi_bready) begin
            awready_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         wready_ff <= 1'b1;
         w_held_ff <= 1'b0;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
      end else if (clk_en) begin
         if (w_take) begin
            wready_ff <= 1'b0;
            w_held_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end else if (do_write) begin
            w_held_ff <= 1'b0;
         end else if (bvalid_ff && s_axi_bready) begin
            wready_ff <= 1'b1;
         end
      end
   end

   // Unmapped writes change nothing and answer with an error
   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= ASM_RESP_OKAY;
      end else if (clk_en) begin
         if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= ((awaddr_ff[7:2] == ASM_STATUS_ADDR[7:2])
               || (awaddr_ff[7:2] == ASM_CTRL_ADDR[7:2]))
               ? ASM_RESP_OKAY : ASM_RESP_SLVERR;
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read channels
   // ----------------------------------------------------------------
   assign ar_take = s_axi_arvalid & arready_ff;

   always_comb begin
      nxt_rdata = 32'h0;
      nxt_rresp = ASM_RESP_OKAY;
      if (s_axi_araddr[7:2] == ASM_STATUS_ADDR[7:2]) begin
         nxt_rdata[7:0] = {status_ff, flag_ff};
      end else if (s_axi_araddr[7:2] == ASM_CTRL_ADDR[7:2]) begin
         nxt_rdata[ASM_CTRL_W-1:0] = ctrl_ff;
      end else begin
         nxt_rresp = ASM_RESP_SLVERR;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rresp_ff <= ASM_RESP_OKAY;
         rdata_ff <= 32'h0;
      end else if (clk_en) begin
         if (ar_take) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
         end else if (rvalid_ff && s_axi_rready) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
         end
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rdata = rdata_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n_ff);

   chk_rpm_all_quiet: assert property (
      clk_en && !ctrl_ff.full_performance_mode |=> status_ff == 4'h0)
      else $error("monitor active outside full performance mode");

   chk_short_dom2_cause: assert property (
      clk_en |=> status_ff.short_dom2 == $past(
         ctrl_ff.dom2_regulator_enable & ctrl_ff.full_performance_mode
         & cond_sync.short_dom2))
      else $error("dom2 short status wrong");

   chk_short_dom1_cause: assert property (
      clk_en |=> status_ff.short_dom1 == $past(
         ctrl_ff.dom1_regulator_enable & ctrl_ff.full_performance_mode
         & cond_sync.short_dom1))
      else $error("dom1 short status wrong");

   chk_lowvolt_dom2_cause: assert property (
      clk_en && ctrl_ff.dom2_supply_on && ctrl_ff.full_performance_mode
      |=> status_ff.lowvolt_dom2 == $past(cond_sync.lowvolt_dom2))
      else $error("dom2 low-voltage status wrong");

   chk_lowvolt_dom1_off: assert property (
      clk_en && !ctrl_ff.dom1_supply_on |=> !status_ff.lowvolt_dom1)
      else $error("dom1 low-voltage set with supply off");

   chk_status_ignores_write: assert property (
      clk_en && wr_status && nxt_status == status_ff
      |=> $stable(status_ff))
      else $error("status bits moved on a bus write");

   chk_status_read_data: assert property (
      clk_en && ar_take && s_axi_araddr == ASM_STATUS_ADDR
      |=> rvalid_ff && rresp_ff == ASM_RESP_OKAY
         && rdata_ff == {24'h0, $past(status_ff), $past(flag_ff)})
      else $error("status read returned wrong data");

   chk_reset_short_clear: assert property (
      $rose(rst_n_ff) |-> status_ff.short_dom2 == 1'b0
         && status_ff.short_dom1 == 1'b0 && flag_ff[3:2] == 2'h0)
      else $error("short bits not cleared by reset");

   chk_read_answer_hold: assert property (
      rvalid_ff && !s_axi_rready |=> rvalid_ff && $stable(rdata_ff))
      else $error("read answer dropped before taken");

   chk_write_answer_time: assert property (
      clk_en && do_write |=> bvalid_ff ##0 !aw_held_ff && !w_held_ff)
      else $error("write answer late");

endmodule : asm_status_top

/* File: test/asm_status_top_test.sv */
// Testbench: supply monitor status register over AXI4-Lite
module asm_status_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   import asm_pkg::*;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic ref_clk;
   logic rst_b;
   logic clk_en;
   asm_cond_s analog_cmp;
   logic [7:0] s_axi_awaddr;
   logic s_axi_awvalid;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_wvalid;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready;
   logic [7:0] s_axi_araddr;
   logic s_axi_arvalid;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready;
   int err_total;
   int checks_done;

   asm_status_top u_dut (
      .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
      .analog_cmp(analog_cmp),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready)
   );

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Status is live only with full mode and the matching enable
   function automatic logic [3:0] exp_status(input asm_ctrl_s k,
                                             input asm_cond_s c);
      logic [3:0] s;
      s[3] = c.short_dom2 & k.dom2_regulator_enable;
      s[2] = c.short_dom1 & k.dom1_regulator_enable;
      s[1] = c.lowvolt_dom2 & k.dom2_supply_on;
      s[0] = c.lowvolt_dom1 & k.dom1_supply_on;
      return k.full_performance_mode ? s : 4'h0;
   endfunction : exp_status

   task automatic give_verdict();
      $display("Counts: %0d checks, %0d mismatches", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      checks_done++;
      if (seen !== exp) begin
         $display("CHECK FAILED at %0t: %s seen %h expected %h",
                  $time, what, seen, exp);
         err_total++;
      end
   endtask : check

   task automatic timed_out();
      $display("CHECK FAILED at %0t: bus answer never came", $time);
      err_total++;
      give_verdict();
   endtask : timed_out

   // Starts one edge after the previous release, so no double drive
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                            input logic [3:0] s, output logic [1:0] r);
      int n;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (n == 50) timed_out();
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      int n;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (n == 50) timed_out();
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_read

   task automatic wr_ok(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s);
      logic [1:0] r;
      axi_write(a, d, s, r);
      check(32'(r), 32'(ASM_RESP_OKAY), "write response");
   endtask : wr_ok

   // Reads the status word and compares status and flag nibbles
   task automatic rd_stat(input logic [3:0] st, input logic [3:0] fl);
      logic [31:0] d;
      logic [1:0] r;
      axi_read(ASM_STATUS_ADDR, d, r);
      check(32'(r), 32'(ASM_RESP_OKAY), "status read response");
      check(d, {24'h0, st, fl}, "word");
   endtask : rd_stat

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      asm_ctrl_s k;
      asm_cond_s c;
      logic [3:0] e;
      err_total = 0;
      checks_done = 0;
      rst_b = 1'b0;
      clk_en = 1'b1;
      analog_cmp = asm_cond_s'(4'h3);
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      void'($urandom(32'hd8ca5d09));
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (8) @(posedge ref_clk);
      // Short bits clear, low-voltage bits follow the comparator level
      rd_stat(4'h3, 4'h3);
      axi_read(ASM_CTRL_ADDR, d, r);
      check(d, 32'h1f, "control reset value");
      analog_cmp <= asm_cond_s'(4'h0);
      repeat (6) @(posedge ref_clk);
      wr_ok(ASM_STATUS_ADDR, 32'h0f, 4'hf);
      rd_stat(4'h0, 4'h0);
      $display("test reset done");

      for (int i = 0; i < 14; i++) begin
         k = asm_ctrl_s'(5'($urandom));
         c = asm_cond_s'(4'($urandom));
         if (i == 0) k = asm_ctrl_s'(5'h1e);
         if (i == 0 || i == 1) c = asm_cond_s'(4'hf);
         if (i == 1) k = asm_ctrl_s'(5'h1f);
         wr_ok(ASM_CTRL_ADDR, 32'(k), 4'h1);
         analog_cmp <= c;
         repeat (6) @(posedge ref_clk);
         e = exp_status(k, c);
         rd_stat(e, e);
         // Clear while the condition holds; status bits ignore the write
         wr_ok(ASM_STATUS_ADDR, 32'hff, 4'hf);
         rd_stat(e, e);
         analog_cmp <= asm_cond_s'(4'h0);
         repeat (6) @(posedge ref_clk);
         rd_stat(4'h0, e);
         wr_ok(ASM_STATUS_ADDR, 32'h00, 4'hf);
         rd_stat(4'h0, e);
         wr_ok(ASM_STATUS_ADDR, 32'hff, 4'h0);
         rd_stat(4'h0, e);
         wr_ok(ASM_STATUS_ADDR, 32'h0f, 4'h1);
         rd_stat(4'h0, 4'h0);
      end
      $display("test random monitor done");

      // An unused offset answers with an error and changes nothing
      axi_write(8'h40, 32'hff, 4'hf, r);
      check(32'(r), 32'(ASM_RESP_SLVERR), "unmapped write response");
      axi_read(8'h40, d, r);
      check(32'(r), 32'(ASM_RESP_SLVERR), "unmapped read response");
      check(d, 32'h0, "unmapped read data");
      rd_stat(4'h0, 4'h0);
      axi_read(ASM_CTRL_ADDR, d, r);
      check(d, 32'(k), "control after unmapped write");
      $display("test unmapped done");

      // Frozen clock enable: a comparator pulse must go unseen
      wr_ok(ASM_CTRL_ADDR, 32'(ASM_CTRL_RST), 4'h1);
      clk_en <= 1'b0;
      analog_cmp <= asm_cond_s'(4'hf);
      repeat (6) @(posedge ref_clk);
      analog_cmp <= asm_cond_s'(4'h0);
      repeat (2) @(posedge ref_clk);
      clk_en <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rd_stat(4'h0, 4'h0);
      $display("test clock enable done");

      // Mid-run reset must drop sticky short flags; only the
      // low-voltage bits come back, following the comparator level
      analog_cmp <= asm_cond_s'(4'hf);
      repeat (6) @(posedge ref_clk);
      rd_stat(4'hf, 4'hf);
      rst_b <= 1'b0;
      analog_cmp <= asm_cond_s'(4'h3);
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rd_stat(4'h3, 4'h3);
      axi_read(ASM_CTRL_ADDR, d, r);
      check(d, 32'(ASM_CTRL_RST), "control after reset");
      $display("test mid-run reset done");
      give_verdict();
   end

endmodule : asm_status_top_test
